// file: tlic_cfg.svh
`ifndef TLIC_CFG_SVH
`define TLIC_CFG_SVH

// ************************************************
// Register offsets (byte addresses)
// ************************************************
`define TLIC_ADDR_W        8
`define TLIC_OFF_RESET_CTL 8'h00
`define TLIC_OFF_INT_CTL   8'h04
`define TLIC_OFF_FLAG      8'h08
`define TLIC_OFF_ENABLE    8'h0C
`define TLIC_OFF_PRIO      8'h10
`define TLIC_OFF_TMR_CTL   8'h14
`define TLIC_OFF_TMR_CNT   8'h18
`define TLIC_OFF_STATUS    8'h1C

// ************************************************
// Field positions and reset values
// ************************************************
`define TLIC_BIT_PRIO_EN   7
`define TLIC_BIT_GLB_HI    7
`define TLIC_BIT_GLB_LO    6
`define TLIC_BIT_TMR_RUN   0
`define TLIC_NUM_SRC       8
`define TLIC_EXT_MASK      8'h0F
`define TLIC_TMR3_SRC      4
`define TLIC_RST_BYTE      8'h00
`define TLIC_PC_W          21
`define TLIC_VEC_HI        21'h000008
`define TLIC_VEC_LO        21'h000018
`define TLIC_TMR_MAX       16'hFFFF
`define TLIC_TMR_ZERO      16'h0000
`define TLIC_RESP_OKAY     2'b00
`define TLIC_RESP_SLVERR   2'b10
`define TLIC_EVT_LATENCY   3
`endif

// file: tlic_core_model.sv
`timescale 1ns/1ps
`include "tlic_cfg.svh"
// ************************************************
// Core sequencer stand-in
// ************************************************
module tlic_core_model (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  branchStb,
   input  wire logic                  retReq,
   output      logic [`TLIC_PC_W-1:0] corePc,
   output      logic                  retInsStb
);
   // New return point after each branch, so a stale push is seen
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         corePc <= 21'h000100;
      end else if (branchStb) begin
         corePc <= 21'($urandom);
      end
   end
   // Return instruction as a one-cycle pulse on request
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         retInsStb <= 1'b0;
      end else begin
         retInsStb <= retReq;
      end
   end
endmodule

// file: tlic_pkg.sv
package tlic_pkg;
   // Service level, one-hot
   typedef enum logic [3:0] {
      LVL_IDLE     = 4'b0001,
      LVL_LOW      = 4'b0010,
      LVL_HIGH     = 4'b0100,
      LVL_HIGH_LOW = 4'b1000
   } tlic_lvl_t;
endpackage

// file: tlic_timer3.sv
`timescale 1ns/1ps
`include "tlic_cfg.svh"
module tlic_timer3 (
   input  wire logic ref_clk,
   input  wire logic rst,
   tlic_tmr_if.tmr   tmr
);
   import tlic_pkg::*;
   logic [15:0] count_q; // Counter
   logic        ovf_q;   // Wrap pulse
   // ************************************************
   // Counter
   // ************************************************
   // Load beats counting, so a write is never lost
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_q <= `TLIC_TMR_ZERO;
      end else if (tmr.load) begin
         count_q <= tmr.loadVal;
      end else if (tmr.run) begin
         count_q <= 16'(count_q + 16'h0001);
      end
   end
   // Wrap pulse, one cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= tmr.run && !tmr.load && count_q == `TLIC_TMR_MAX;
      end
   end
   assign tmr.count = count_q;
   assign tmr.ovf   = ovf_q;
   // ************************************************
   // Checks
   // ************************************************
   AST_TMR_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
      tmr.run && !tmr.load && count_q == `TLIC_TMR_MAX |=> count_q == `TLIC_TMR_ZERO && ovf_q)
      else $error("Timer did not wrap to zero with overflow");
   COV_TMR_WRAP: cover property (@(posedge ref_clk) disable iff (rst) ovf_q);
endmodule

// file: tlic_tmr_if.sv
`timescale 1ns/1ps
// Controller to timer signals
interface tlic_tmr_if;
   logic        run;     // Count enable
   logic        load;    // Software load pulse
   logic [15:0] loadVal; // Load value
   logic [15:0] count;   // Current count
   logic        ovf;     // Wrap pulse
   modport tmr (input run, input load, input loadVal, output count, output ovf);
   modport ctl (output run, output load, output loadVal, input count, input ovf);
endinterface

// file: tlic_top.sv
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "tlic_cfg.svh"
module tlic_top (
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   // AXI4-Lite slave
   input  wire logic [`TLIC_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output      logic                     s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output      logic                     s_axi_wready,
   output      logic [1:0]               s_axi_bresp,
   output      logic                     s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [`TLIC_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output      logic                     s_axi_arready,
   output      logic [31:0]              s_axi_rdata,
   output      logic [1:0]               s_axi_rresp,
   output      logic                     s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // Source events and core sequencer
   input  wire logic [`TLIC_NUM_SRC-1:0] srcEvent,
   input  wire logic [`TLIC_PC_W-1:0]    corePc,
   input  wire logic                     retInsStb,
   output      logic                     branchStb,
   output      logic [`TLIC_PC_W-1:0]    branchVector,
   output      logic [`TLIC_PC_W-1:0]    pushAddr
);
   import tlic_pkg::*;

   // ************************************************
   // Declarations
   // ************************************************
   localparam int N = `TLIC_NUM_SRC;
   logic                    awHeld_q;   // Write address taken
   logic [`TLIC_ADDR_W-1:0] awAddr_q;   // Held write address
   logic                    wHeld_q;    // Write data taken
   logic [15:0]             wData_q;    // Held write data
   logic [1:0]              wStrb_q;    // Held low strobes
   logic                    bvalid_q;   // Write answer
   logic [1:0]              bresp_q;    // Write status
   logic                    rvalid_q;   // Read answer
   logic [1:0]              rresp_q;    // Read status
   logic [31:0]             rdata_q;    // Read data
   logic                    wrFire;     // Write carried out
   logic                    wrLow;      // Low byte written
   logic                    prioEn_q;   // priority_levels_enable
   logic                    glbHi_q;    // Bit 7: global or high-level enable
   logic                    glbLo_q;    // Bit 6: peripheral or low-level enable
   logic [N-1:0]            evt_q;      // Registered events
   logic [N-1:0]            flag_q;     // Event flags
   logic [N-1:0]            enable_q;   // Individual enables
   logic [N-1:0]            prio_q;     // 1 = high level
   logic                    tmrRun_q;   // Timer3 count enable
   tlic_lvl_t               lvl_q;      // Service level
   logic                    branch_q;   // Branch strobe
   logic [`TLIC_PC_W-1:0]   vector_q;   // Chosen vector
   logic [`TLIC_PC_W-1:0]   push_q;     // Return address
   logic [N-1:0]            pend;       // Flag and enable
   logic                    hiActive;   // High service running
   logic                    hiPend;     // High level request
   logic                    loPend;     // Low level request
   logic                    cmPend;     // Compatibility request
   logic                    canAcc;     // Acceptance allowed
   logic                    accHi;      // Accept to 0008h
   logic                    accLo;      // Accept to 0018h
   logic                    ctlWr;      // Control register write

   tlic_tmr_if tmrBus ();

   // ************************************************
   // Address decode
   // ************************************************
   // Shared by read and write so both agree on the map
   function automatic logic tlic_mapped(input logic [`TLIC_ADDR_W-1:0] a);
      case (a)
         `TLIC_OFF_RESET_CTL, `TLIC_OFF_INT_CTL, `TLIC_OFF_FLAG, `TLIC_OFF_ENABLE,
         `TLIC_OFF_PRIO, `TLIC_OFF_TMR_CTL, `TLIC_OFF_TMR_CNT, `TLIC_OFF_STATUS:
            return 1'b1;
         default:
            return 1'b0;
      endcase
   endfunction

   // Low byte write to a given register
   function automatic logic tlic_wr(input logic [`TLIC_ADDR_W-1:0] a);
      return wrLow && awAddr_q == a;
   endfunction

   // ************************************************
   // AXI4-Lite write path
   // ************************************************
   // One write at a time: new address and data taken once carried out; next write waits for the answer
   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready  = !wHeld_q;
   assign wrFire        = awHeld_q && wHeld_q && !bvalid_q;
   assign wrLow         = wrFire && wStrb_q[0];

   // Address capture
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
      end else if (wrFire) begin
         awHeld_q <= 1'b0;
      end
   end

   // Data capture, only the low half matters
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wHeld_q <= 1'b0;
         wData_q <= '0;
         wStrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_q <= 1'b1;
         wData_q <= s_axi_wdata[15:0];
         wStrb_q <= s_axi_wstrb[1:0];
      end else if (wrFire) begin
         wHeld_q <= 1'b0;
      end
   end

   // Write answer, error for unmapped offsets
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `TLIC_RESP_OKAY;
      end else if (wrFire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= tlic_mapped(awAddr_q) ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ************************************************
   // AXI4-Lite read path
   // ************************************************
   assign s_axi_arready = !rvalid_q;

   // Read data sampled at address acceptance
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rresp_q  <= `TLIC_RESP_OKAY;
         rdata_q  <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= tlic_mapped(s_axi_araddr) ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
         case (s_axi_araddr)
            `TLIC_OFF_RESET_CTL: rdata_q <= {24'h000000, prioEn_q, 7'h00};
            `TLIC_OFF_INT_CTL:   rdata_q <= {24'h000000, glbHi_q, glbLo_q, 6'h00};
            `TLIC_OFF_FLAG:      rdata_q <= {24'h000000, flag_q};
            `TLIC_OFF_ENABLE:    rdata_q <= {24'h000000, enable_q};
            `TLIC_OFF_PRIO:      rdata_q <= {24'h000000, prio_q};
            `TLIC_OFF_TMR_CTL:   rdata_q <= {31'h00000000, tmrRun_q};
            `TLIC_OFF_TMR_CNT:   rdata_q <= {16'h0000, tmrBus.count};
            `TLIC_OFF_STATUS:    rdata_q <= {28'h0000000, lvl_q};
            default:             rdata_q <= 32'h00000000;
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp  = rresp_q;
   assign s_axi_rdata  = rdata_q;

   // ************************************************
   // Configuration registers
   // ************************************************
   // Priority off after reset: compatibility mode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prioEn_q <= 1'b0;
      end else if (tlic_wr(`TLIC_OFF_RESET_CTL)) begin
         prioEn_q <= wData_q[`TLIC_BIT_PRIO_EN];
      end
   end

   // Enables and priorities per source
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         enable_q <= `TLIC_RST_BYTE;
         prio_q   <= `TLIC_RST_BYTE;
      end else begin
         if (tlic_wr(`TLIC_OFF_ENABLE)) begin
            enable_q <= wData_q[N-1:0];
         end
         if (tlic_wr(`TLIC_OFF_PRIO)) begin
            prio_q <= wData_q[N-1:0];
         end
      end
   end

   // Timer3 run control
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tmrRun_q <= 1'b0;
      end else if (tlic_wr(`TLIC_OFF_TMR_CTL)) begin
         tmrRun_q <= wData_q[`TLIC_BIT_TMR_RUN];
      end
   end

   // Timer3 counter lives in its own module
   assign tmrBus.run     = tmrRun_q;
   assign tmrBus.load    = wrFire && wStrb_q == 2'b11 && awAddr_q == `TLIC_OFF_TMR_CNT;
   assign tmrBus.loadVal = wData_q;

   tlic_timer3 uTimer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tmr     (tmrBus.tmr)
   );

   // ************************************************
   // Event flags
   // ************************************************
   // Extra stage gives a fixed three-cycle latency
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         evt_q <= '0;
      end else begin
         evt_q <= srcEvent | (N'(tmrBus.ovf) << `TLIC_TMR3_SRC);
      end
   end

   // Hardware set beats a software clear in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flag_q <= `TLIC_RST_BYTE;
      end else if (tlic_wr(`TLIC_OFF_FLAG)) begin
         flag_q <= wData_q[N-1:0] | evt_q;
      end else begin
         flag_q <= flag_q | evt_q;
      end
   end

   // ************************************************
   // Request evaluation
   // ************************************************
   assign pend     = flag_q & enable_q;
   assign hiActive = lvl_q == LVL_HIGH || lvl_q == LVL_HIGH_LOW;
   assign ctlWr    = tlic_wr(`TLIC_OFF_INT_CTL);

   // Priority mode: bit 7 gates high, bit 6 gates low
   assign hiPend = prioEn_q && glbHi_q && |(pend & prio_q);
   assign loPend = prioEn_q && glbLo_q && !hiActive && |(pend & ~prio_q);

   // Compatibility: priority ignored, bit 6 gates peripherals
   assign cmPend = !prioEn_q && glbHi_q
                   && |(pend & (`TLIC_EXT_MASK | (glbLo_q ? ~`TLIC_EXT_MASK : 8'h00)));

   // Hold off while a branch, enable write or return is in flight
   assign canAcc = !branch_q && !ctlWr && !retInsStb;
   assign accHi  = canAcc && (hiPend || cmPend);
   assign accLo  = canAcc && loPend && !hiPend;

   // ************************************************
   // Global enables
   // ************************************************
   // Cleared on acceptance, set again by the return
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         glbHi_q <= 1'b0;
      end else if (accHi) begin
         glbHi_q <= 1'b0;
      end else if (retInsStb && (!prioEn_q || hiActive)) begin
         glbHi_q <= 1'b1;
      end else if (ctlWr) begin
         glbHi_q <= wData_q[`TLIC_BIT_GLB_HI];
      end
   end

   // Low level enable, peripheral gate in compatibility
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         glbLo_q <= 1'b0;
      end else if (accLo) begin
         glbLo_q <= 1'b0;
      end else if (retInsStb && prioEn_q && lvl_q == LVL_LOW) begin
         glbLo_q <= 1'b1;
      end else if (ctlWr) begin
         glbLo_q <= wData_q[`TLIC_BIT_GLB_LO];
      end
   end

   // ************************************************
   // Service level
   // ************************************************
   // Tracks nesting so a return restores the right enable
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lvl_q <= LVL_IDLE;
      end else if (prioEn_q) begin
         case (lvl_q)
            LVL_IDLE: begin
               if (accHi) begin
                  lvl_q <= LVL_HIGH;
               end else if (accLo) begin
                  lvl_q <= LVL_LOW;
               end
            end
            LVL_LOW: begin
               if (accHi) begin
                  lvl_q <= LVL_HIGH_LOW;
               end else if (retInsStb) begin
                  lvl_q <= LVL_IDLE;
               end
            end
            LVL_HIGH: begin
               if (retInsStb) begin
                  lvl_q <= LVL_IDLE;
               end
            end
            LVL_HIGH_LOW: begin
               if (retInsStb) begin
                  lvl_q <= LVL_LOW;
               end
            end
            default: begin
               lvl_q <= LVL_IDLE;
            end
         endcase
      end else begin
         // Compatibility mode keeps no nesting
         lvl_q <= LVL_IDLE;
      end
   end

   // ************************************************
   // Branch request to the core
   // ************************************************
   // One-cycle strobe, vector and return address
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         branch_q <= 1'b0;
         vector_q <= `TLIC_VEC_HI;
         push_q   <= '0;
      end else begin
         branch_q <= accHi || accLo;
         if (accHi || accLo) begin
            vector_q <= accLo ? `TLIC_VEC_LO : `TLIC_VEC_HI;
            push_q   <= corePc;
         end
      end
   end
   assign branchStb    = branch_q;
   assign branchVector = vector_q;
   assign pushAddr     = push_q;

   // ************************************************
   // Checks
   // ************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_HI_VECTOR: assert property (accHi |=> branch_q && vector_q == `TLIC_VEC_HI)
      else $error("High acceptance did not branch to high vector");
   AST_LO_VECTOR: assert property (accLo |=> branch_q && vector_q == `TLIC_VEC_LO)
      else $error("Low acceptance did not branch to low vector");
   AST_COMPAT_VECTOR: assert property (branch_q && !$past(prioEn_q) |-> vector_q == `TLIC_VEC_HI)
      else $error("Compatibility branch not at high vector");
   AST_PREEMPT: assert property (lvl_q == LVL_LOW && hiPend && canAcc |=> lvl_q == LVL_HIGH_LOW)
      else $error("High request did not preempt low service");
   AST_CLEAR_ENABLE: assert property (accHi |=> !glbHi_q ##1 (!glbHi_q || $past(retInsStb || ctlWr)))
      else $error("Global enable not cleared on acceptance");
   AST_NO_LOW_IN_HIGH: assert property (hiActive |-> !accLo)
      else $error("Low accepted during high service");
   AST_RETURN_RESTORE: assert property (retInsStb && !prioEn_q && !ctlWr |=> glbHi_q)
      else $error("Return did not restore global enable");
   AST_FLAG_SET: assert property (|evt_q |=> (flag_q & $past(evt_q)) == $past(evt_q))
      else $error("Event did not set its flag");
   AST_HIGH_FIRST: assert property (hiPend && loPend && canAcc |-> accHi && !accLo)
      else $error("Low accepted ahead of high");
   AST_LATENCY: assert property (srcEvent[0] && enable_q[0] && glbHi_q && !prioEn_q
      && !branch_q ##1 (enable_q[0] && glbHi_q && !prioEn_q && canAcc)[*2] |-> ##1 branch_q)
      else $error("External event not vectored in three cycles");

   COV_HI: cover property (accHi && prioEn_q);
   COV_LO: cover property (accLo);
   COV_NEST: cover property (lvl_q == LVL_HIGH_LOW);
   COV_COMPAT: cover property (accHi && !prioEn_q);
endmodule

// file: two_level_interrupt_controller_tb_top.sv
`timescale 1ns/1ps
`include "tlic_cfg.svh"
module two_level_interrupt_controller_tb_top;
   import tlic_pkg::*;
   // ************************************************
   // Stimulus and observed signals
   // ************************************************
   logic        ref_clk = 0, rst = 1, retReq = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, srcEvent = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, branchStb, retInsStb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [20:0] branchVector, pushAddr, corePc, vec, pc, pcExp;
   logic [7:0]  en;
   logic [31:0] ic;
   int          fails = 0, samples_checked = 0, k, b, nBr = 0, n0;
   always #25 ref_clk = ~ref_clk;
   tlic_top u_dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .srcEvent(srcEvent), .corePc(corePc), .retInsStb(retInsStb), .branchStb(branchStb),
      .branchVector(branchVector), .pushAddr(pushAddr));
   tlic_core_model u_core (.ref_clk(ref_clk), .rst(rst), .branchStb(branchStb), .retReq(retReq),
      .corePc(corePc), .retInsStb(retInsStb));
   // Branch monitor: a branch may fire inside a bus task, so it is never missed
   always @(negedge ref_clk) begin
      if (branchStb === 1'b1) begin
         nBr++;
         vec = branchVector;
         pc = pushAddr;
         pcExp = corePc;
      end
   end
   // ************************************************
   // Reporting
   // ************************************************
   task close_out;
      $display("Checked %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // ************************************************
   // Bus master; ready sampled mid-cycle equals its edge value
   // ************************************************
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, bv;
      bv = 0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; !bv; n++) begin
         if (n > 40) begin
            fails++;
            close_out();
         end
         @(negedge ref_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         bv = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge ref_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask
   task rdr(input logic [7:0] a);
      logic ta, rv;
      rv = 0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; !rv; n++) begin
         if (n > 40) begin
            fails++;
            close_out();
         end
         @(negedge ref_clk);
         ta = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge ref_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask
   task rc(input logic [7:0] a, input string nm, input logic [31:0] e);
      rdr(a);
      chk(nm, rd, e);
   endtask
   // ************************************************
   // Event pulse, then watch for a branch; k is -1 if none
   // ************************************************
   task evt(input logic [7:0] m, input int lim);
      k = -1;
      @(posedge ref_clk);
      srcEvent <= m;
      for (int i = 0; i < lim && k < 0; i++) begin
         @(negedge ref_clk);
         if (branchStb === 1'b1) k = i;
         @(posedge ref_clk);
         srcEvent <= 8'h00;
      end
   endtask
   // Return instruction through the core model
   task ret;
      @(posedge ref_clk);
      retReq <= 1'b1;
      @(posedge ref_clk);
      retReq <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   // ************************************************
   // Main sequence; control writes go one register at a time
   // ************************************************
   initial begin
      void'($urandom(32326));
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rc(`TLIC_OFF_RESET_CTL, "prioEnable", 32'h0);
      rc(`TLIC_OFF_STATUS, "status", 32'(LVL_IDLE));
      rdr(8'h20);
      chk("rdResp", 32'(rsp), 32'(`TLIC_RESP_SLVERR));
      wr(8'h24, 32'hFF);
      chk("wrResp", 32'(rsp), 32'(`TLIC_RESP_SLVERR));
      // Compatibility: flag sets while disabled, branch when enabled
      wr(`TLIC_OFF_PRIO, 32'h01);
      wr(`TLIC_OFF_ENABLE, 32'h0E);
      wr(`TLIC_OFF_INT_CTL, 32'h80);
      evt(8'h01, 8);
      chk("noBranch", 32'(k), 32'hFFFFFFFF);
      rc(`TLIC_OFF_FLAG, "flag", 32'h01);
      n0 = nBr;
      wr(`TLIC_OFF_ENABLE, 32'h0F);
      evt(8'h00, 8);
      chk("branchOnEnable", 32'(nBr - n0), 32'h1);
      chk("vecCompat", 32'(vec), 32'(`TLIC_VEC_HI));
      rc(`TLIC_OFF_INT_CTL, "enCleared", 32'h00);
      wr(`TLIC_OFF_FLAG, 32'h00);
      ret();
      rc(`TLIC_OFF_INT_CTL, "enBack", 32'h80);
      evt(8'h01, 8);
      chk("latency", 32'(k), 32'(`TLIC_EVT_LATENCY));
      chk("vecIgnorePrio", 32'(vec), 32'(`TLIC_VEC_HI));
      chk("push", 32'(pc), 32'(pcExp));
      // Random gating of sources by the two control bits
      for (int i = 0; i < 10; i++) begin
         en = 8'($urandom);
         b = $urandom % 8;
         ic = ($urandom % 4) << 6;
         wr(`TLIC_OFF_FLAG, 32'h00);
         wr(`TLIC_OFF_ENABLE, 32'(en));
         wr(`TLIC_OFF_INT_CTL, ic);
         evt(8'h01 << b, 8);
         chk("gated", 32'(k >= 0), 32'(en[b] && ic[7] && (b < 4 || ic[6])));
         if (k >= 0) chk("vecRand", 32'(vec), 32'(`TLIC_VEC_HI));
      end
      // Priority mode
      wr(`TLIC_OFF_FLAG, 32'h00);
      wr(`TLIC_OFF_RESET_CTL, 32'h80);
      wr(`TLIC_OFF_PRIO, 32'h01);
      wr(`TLIC_OFF_ENABLE, 32'h03);
      wr(`TLIC_OFF_INT_CTL, 32'hC0);
      evt(8'h03, 8);
      chk("highFirst", 32'(vec), 32'(`TLIC_VEC_HI));
      rc(`TLIC_OFF_INT_CTL, "highCleared", 32'h40);
      rc(`TLIC_OFF_STATUS, "stHigh", 32'(LVL_HIGH));
      evt(8'h00, 8);
      chk("lowHeld", 32'(k), 32'hFFFFFFFF);
      wr(`TLIC_OFF_FLAG, 32'h02);
      n0 = nBr;
      ret();
      evt(8'h00, 8);
      chk("lowBranch", 32'(nBr - n0), 32'h1);
      chk("lowVec", 32'(vec), 32'(`TLIC_VEC_LO));
      rc(`TLIC_OFF_INT_CTL, "lowCleared", 32'h80);
      evt(8'h01, 8);
      chk("preempt", 32'(vec), 32'(`TLIC_VEC_HI));
      rc(`TLIC_OFF_STATUS, "stNested", 32'(LVL_HIGH_LOW));
      // Second reset, then Timer3 wrap as a peripheral source
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rc(`TLIC_OFF_RESET_CTL, "prioAgain", 32'h0);
      wr(`TLIC_OFF_ENABLE, 32'h10);
      wr(`TLIC_OFF_INT_CTL, 32'hC0);
      wr(`TLIC_OFF_TMR_CNT, 32'h0000FFFE);
      rc(`TLIC_OFF_TMR_CNT, "tmrLoad", 32'h0000FFFE);
      wr(`TLIC_OFF_TMR_CTL, 32'h01);
      evt(8'h00, 20);
      chk("tmrBranch", 32'(k >= 0), 32'h1);
      chk("tmrVec", 32'(vec), 32'(`TLIC_VEC_HI));
      rdr(`TLIC_OFF_FLAG);
      chk("tmrFlag", rd & 32'h10, 32'h10);
      close_out();
   end
endmodule
